// >>> rtl/dmsc_regs.sv
// DSCP priority map (0x36-0x3f), snoop/mirror global controls and WRED color map
// Overview of operation
// [RL1] Register 0x035b gives the priority of DSCP 0x36 from bits 2:0 and of 0x37 from bits 6:4.
// [RL2] Register 0x035c gives the priority of DSCP 0x38 from bits 2:0 and of 0x39 from bits 6:4.
// [RL3] Register 0x035d gives the priority of DSCP 0x3a from bits 2:0 and of 0x3b from bits 6:4.
// [RL4] Register 0x035e gives the priority of DSCP 0x3c from bits 2:0 and of 0x3d from bits 6:4.
// [RL5] Register 0x035f gives 0x3e and 0x3f, and every priority field is read/write with reset zero.
// [RL6] With the IGMP enable bit 6 set every IGMP packet is trapped to the host port, else none.
// [RL7] With the MLD enable bit 2 set every MLD packet is trapped to the host port, else none.
// [RL8] With the MLD option bit set, next header 43/44/50/51/60 (direct or after hop-by-hop) means MLD.
// [RL9] With the MLD option bit clear, next header 1/58 (direct or after hop-by-hop) means MLD.
// [RL10] With sniff select bit 0 set a frame is mirrored only if source and destination both match.
// [RL11] With sniff select clear (reset) a frame is mirrored if source or destination matches.
// [RL12] The global mirror decision is qualified by the per-port ingress mirror enables from outside.
// [RL13] WRED bits 5:4 hold the red DSCP value, read/write, reset 11b.
// [RL14] WRED bits 3:2 hold the yellow DSCP value, read/write, reset 10b.
// [RL15] WRED bits 1:0 hold the green DSCP value, read/write, reset 01b.
// [RL16] Reserved bits read as zero and writes to them have no effect.
module dmsc_regs
  import dmsc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Management register access
  input  wire dmsc_req_s         req_in,
  output logic [DMSC_DW-1:0]     rdata_out,
  output logic                   rvalid_out,
  output logic                   hit_out,
  // DSCP lookup
  input  wire logic [5:0]        dscp_in,
  output logic                   dscp_hit_out,
  output logic [2:0]             dscp_prio_out,
  // Snoop classification
  input  wire logic              pkt_igmp_in,
  input  wire logic              pkt_ipv6_in,
  input  wire logic [7:0]        ipv6_nh_in,
  input  wire logic [7:0]        hbh_nh_in,
  output logic                   mld_match_out,
  output logic                   host_trap_out,
  // Mirror filter
  input  wire logic              src_sniff_match_in,
  input  wire logic              dst_sniff_match_in,
  input  wire logic              port_mirror_en_in,
  output logic                   mirror_sel_out,
  // Configuration view
  output dmsc_color_s            wred_color_out,
  output logic                   sniff_and_out
);

  logic [7:0] map_q [DMSC_NUM_MAP];
  logic [7:0] next_map [DMSC_NUM_MAP];
  logic [7:0] ctrl_q;
  logic [7:0] next_ctrl;
  logic [7:0] wred_q;
  logic [7:0] next_wred;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       next_hit;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       hit_q;

  function automatic logic [2:0] map_index(input logic [15:0] a);
    logic [15:0] d;
    d = a - DMSC_OFS_MAP_36;
    return d[2:0];
  endfunction

  wire logic map_sel = (req_in.addr >= DMSC_OFS_MAP_36) && (req_in.addr <= DMSC_OFS_MAP_3E);
  wire logic wr_go   = req_in.sel && req_in.wr;

  // Register writes; only defined bits are stored
  always_comb begin
    next_ctrl = ctrl_q;
    next_wred = wred_q;
    for (int i = 0; i < DMSC_NUM_MAP; i++) begin
      next_map[i] = map_q[i];
    end
    if (wr_go && map_sel) begin
      next_map[map_index(req_in.addr)] = req_in.wdata & DMSC_MAP_MASK; // [RL5] [RL16]
    end
    if (wr_go && req_in.addr == DMSC_OFS_GLB_CTRL) begin
      next_ctrl = req_in.wdata & DMSC_CTRL_MASK; // [RL16]
    end
    if (wr_go && req_in.addr == DMSC_OFS_WRED_MAP) begin
      next_wred = req_in.wdata & DMSC_WRED_MASK; // [RL13] [RL14] [RL15] [RL16]
    end
  end

  // Read path; unmapped addresses answer zero with hit low
  always_comb begin
    next_rdata  = 8'h00;
    next_hit    = 1'b0;
    next_rvalid = req_in.sel && !req_in.wr;
    if (req_in.sel && map_sel) begin
      next_rdata = map_q[map_index(req_in.addr)] & DMSC_MAP_MASK; // [RL1] [RL16]
      next_hit   = 1'b1;
    end else if (req_in.sel && req_in.addr == DMSC_OFS_GLB_CTRL) begin
      next_rdata = ctrl_q & DMSC_CTRL_MASK;
      next_hit   = 1'b1;
    end else if (req_in.sel && req_in.addr == DMSC_OFS_WRED_MAP) begin
      next_rdata = wred_q & DMSC_WRED_MASK;
      next_hit   = 1'b1;
    end
    if (!next_rvalid) begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DMSC_NUM_MAP; i++) begin
        map_q[i] <= DMSC_MAP_RST; // [RL5]
      end
      ctrl_q   <= DMSC_CTRL_RST;
      wred_q   <= DMSC_WRED_RST; // [RL13] [RL14] [RL15]
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      hit_q    <= 1'b0;
    end else begin
      for (int i = 0; i < DMSC_NUM_MAP; i++) begin
        map_q[i] <= next_map[i];
      end
      ctrl_q   <= next_ctrl;
      wred_q   <= next_wred;
      rdata_q  <= next_rdata;
      rvalid_q <= next_rvalid;
      hit_q    <= next_hit;
    end
  end

  assign rdata_out  = rdata_q;
  assign rvalid_out = rvalid_q;
  assign hit_out    = hit_q;

  // DSCP lookup; codes below 0x36 belong to another bank, so hit is low and prio zero
  logic [5:0] dscp_off;
  logic [2:0] dscp_reg;
  assign dscp_off = dscp_in - DMSC_FIRST_CODE;
  assign dscp_reg = dscp_off[3:1];
  always_comb begin
    dscp_hit_out  = dscp_in >= DMSC_FIRST_CODE;
    dscp_prio_out = 3'h0;
    if (dscp_hit_out) begin
      dscp_prio_out = dscp_off[0] ? map_q[dscp_reg][6:4] : map_q[dscp_reg][2:0]; // [RL1] [RL2] [RL3] [RL4] [RL5]
    end
  end

  // MLD classification
  function automatic logic nh_match(input logic [7:0] nh, input logic opt);
    if (opt) begin
      return nh == DMSC_NH_ROUTE || nh == DMSC_NH_FRAG || nh == DMSC_NH_ESP ||
             nh == DMSC_NH_AH || nh == DMSC_NH_DSTOPT; // [RL8]
    end
    return nh == DMSC_NH_ICMP || nh == DMSC_NH_ICMPV6; // [RL9]
  endfunction

  wire logic mld_opt = ctrl_q[DMSC_BIT_MLD_OPT];
  assign mld_match_out = pkt_ipv6_in && (nh_match(ipv6_nh_in, mld_opt) ||
                         (ipv6_nh_in == DMSC_NH_HOPOPT && nh_match(hbh_nh_in, mld_opt))); // [RL8] [RL9]

  // Host trap; combinational so the forwarding path sees it in the same cycle
  assign host_trap_out = (ctrl_q[DMSC_BIT_IGMP_EN] && pkt_igmp_in) ||  // [RL6]
                         (ctrl_q[DMSC_BIT_MLD_EN] && mld_match_out);   // [RL7]

  // Mirror filter, gated by the per-port ingress mirror enable
  assign sniff_and_out  = ctrl_q[DMSC_BIT_SNIFF_AND];
  assign mirror_sel_out = port_mirror_en_in && (sniff_and_out ? // [RL12]
                          (src_sniff_match_in && dst_sniff_match_in) :  // [RL10]
                          (src_sniff_match_in || dst_sniff_match_in));  // [RL11]

  assign wred_color_out.red    = wred_q[5:4]; // [RL13]
  assign wred_color_out.yellow = wred_q[3:2]; // [RL14]
  assign wred_color_out.green  = wred_q[1:0]; // [RL15]

  // Assertions
  igmp_trap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pkt_igmp_in && ctrl_q[DMSC_BIT_IGMP_EN]) |-> host_trap_out)
    else $error("IGMP packet not trapped"); // [RL6]
  no_trap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ctrl_q[DMSC_BIT_IGMP_EN] == 1'b0 && ctrl_q[DMSC_BIT_MLD_EN] == 1'b0) |-> !host_trap_out)
    else $error("Trap with snooping off"); // [RL7]
  mld_icmp_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pkt_ipv6_in && !mld_opt && ipv6_nh_in == DMSC_NH_ICMPV6) |-> mld_match_out)
    else $error("ICMPv6 not classed MLD"); // [RL9]
  mld_opt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pkt_ipv6_in && mld_opt && ipv6_nh_in == DMSC_NH_HOPOPT && hbh_nh_in == DMSC_NH_DSTOPT) |-> mld_match_out)
    else $error("Hop-by-hop option not classed MLD"); // [RL8]
  sniff_and_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (sniff_and_out && (src_sniff_match_in != dst_sniff_match_in)) |-> !mirror_sel_out)
    else $error("AND mode mirrored half match"); // [RL10]
  sniff_or_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!sniff_and_out && port_mirror_en_in && src_sniff_match_in) |-> mirror_sel_out)
    else $error("OR mode missed source match"); // [RL11]
  port_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !port_mirror_en_in |-> !mirror_sel_out)
    else $error("Mirror without port enable"); // [RL12]
  map_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_go && req_in.addr == DMSC_OFS_MAP_36) |=> (map_q[0] == ($past(req_in.wdata) & DMSC_MAP_MASK)))
    else $error("Map write lost"); // [RL1]
  prio_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (dscp_in == 6'h3e) |-> (dscp_prio_out == map_q[4][2:0]))
    else $error("Wrong priority for 0x3e"); // [RL5]
  prio_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (dscp_in == 6'h39) |-> (dscp_prio_out == map_q[1][6:4]))
    else $error("Wrong priority for 0x39"); // [RL2]
  rsvd_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rvalid_out |-> (rdata_out[7] == 1'b0))
    else $error("Reserved bit 7 read nonzero"); // [RL16]
  wred_red_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_go && req_in.addr == DMSC_OFS_WRED_MAP) |=> (wred_color_out.red == $past(req_in.wdata[5:4])))
    else $error("Red field not written"); // [RL13]
  wred_yellow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL14]
    (wr_go && req_in.addr == DMSC_OFS_WRED_MAP) |=> (wred_color_out.yellow == $past(req_in.wdata[3:2])))
    else $error("Yellow field not written");
  wred_green_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL15]
    (wr_go && req_in.addr == DMSC_OFS_WRED_MAP) |=> (wred_color_out.green == $past(req_in.wdata[1:0])))
    else $error("Green field not written");
  wred_rsvd_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL16]
    wred_q[7:6] == 2'b00)
    else $error("WRED reserved bits set");
  ctrl_rsvd_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL16]
    (ctrl_q & ~DMSC_CTRL_MASK) == 8'h00)
    else $error("Control reserved bits set");
  ctrl_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL6]
    (wr_go && req_in.addr == DMSC_OFS_GLB_CTRL) |=> (ctrl_q == ($past(req_in.wdata) & DMSC_CTRL_MASK)))
    else $error("Control write lost");

  map_write_38_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL2]
    (wr_go && req_in.addr == DMSC_OFS_MAP_38) |=> (map_q[1] == ($past(req_in.wdata) & DMSC_MAP_MASK)))
    else $error("Map 38 write lost");
  map_write_3a_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL3]
    (wr_go && req_in.addr == DMSC_OFS_MAP_3A) |=> (map_q[2] == ($past(req_in.wdata) & DMSC_MAP_MASK)))
    else $error("Map 3a write lost");
  map_write_3c_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL4]
    (wr_go && req_in.addr == DMSC_OFS_MAP_3C) |=> (map_q[3] == ($past(req_in.wdata) & DMSC_MAP_MASK)))
    else $error("Map 3c write lost");
  map_write_3e_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL5]
    (wr_go && req_in.addr == DMSC_OFS_MAP_3E) |=> (map_q[4] == ($past(req_in.wdata) & DMSC_MAP_MASK)))
    else $error("Map 3e write lost");
  map_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL5]
    !wr_go |=> (map_q[0] == $past(map_q[0])))
    else $error("Map changed without write");

  prio_36_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL1]
    (dscp_in == 6'h36) |-> (dscp_prio_out == map_q[0][2:0]))
    else $error("Wrong priority for 0x36");
  prio_37_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL1]
    (dscp_in == 6'h37) |-> (dscp_prio_out == map_q[0][6:4]))
    else $error("Wrong priority for 0x37");
  prio_3a_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL3]
    (dscp_in == 6'h3a) |-> (dscp_prio_out == map_q[2][2:0]))
    else $error("Wrong priority for 0x3a");
  prio_3b_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL3]
    (dscp_in == 6'h3b) |-> (dscp_prio_out == map_q[2][6:4]))
    else $error("Wrong priority for 0x3b");
  prio_3c_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL4]
    (dscp_in == 6'h3c) |-> (dscp_prio_out == map_q[3][2:0]))
    else $error("Wrong priority for 0x3c");
  prio_3d_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL4]
    (dscp_in == 6'h3d) |-> (dscp_prio_out == map_q[3][6:4]))
    else $error("Wrong priority for 0x3d");
  prio_3f_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL5]
    (dscp_in == 6'h3f) |-> (dscp_prio_out == map_q[4][6:4]))
    else $error("Wrong priority for 0x3f");
  prio_miss_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL1]
    !dscp_hit_out |-> (dscp_prio_out == 3'h0))
    else $error("Priority given outside this bank");

  mld_trap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL7]
    (ctrl_q[DMSC_BIT_MLD_EN] && mld_match_out) |-> host_trap_out)
    else $error("MLD packet not trapped");
  igmp_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL6]
    (!ctrl_q[DMSC_BIT_IGMP_EN] && !mld_match_out) |-> !host_trap_out)
    else $error("Trap with IGMP snooping off");
  mld_v4_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL9]
    !pkt_ipv6_in |-> !mld_match_out)
    else $error("Non-IPv6 packet classed MLD");
  mld_opt_route_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL8]
    (pkt_ipv6_in && mld_opt && ipv6_nh_in == DMSC_NH_ROUTE) |-> mld_match_out)
    else $error("Routing header not classed MLD");
  mld_opt_excl_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL8]
    (mld_opt && ipv6_nh_in == DMSC_NH_ICMPV6) |-> !mld_match_out)
    else $error("ICMPv6 classed MLD with option set");
  mld_hbh_icmp_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL9]
    (pkt_ipv6_in && !mld_opt && ipv6_nh_in == DMSC_NH_HOPOPT && hbh_nh_in == DMSC_NH_ICMP) |-> mld_match_out)
    else $error("Hop-by-hop ICMP not classed MLD");

  sniff_both_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL10]
    (sniff_and_out && port_mirror_en_in && src_sniff_match_in && dst_sniff_match_in) |-> mirror_sel_out)
    else $error("AND mode missed full match");
  sniff_or_dst_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL11]
    (!sniff_and_out && port_mirror_en_in && dst_sniff_match_in) |-> mirror_sel_out)
    else $error("OR mode missed destination match");

  read_answer_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL5]
    (req_in.sel && !req_in.wr) |=> rvalid_out)
    else $error("Read not answered");
  idle_rdata_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL16]
    !rvalid_out |-> (rdata_out == 8'h00))
    else $error("Read data outside answer");

endmodule

// >>> common/dmsc_pkg.sv
// Register map, field layout and packet-classification constants for the DSCP/snoop control bank
package dmsc_pkg;
  localparam int          DMSC_AW            = 16;
  localparam int          DMSC_DW            = 8;
  localparam logic [15:0] DMSC_OFS_MAP_36    = 16'h035b;
  localparam logic [15:0] DMSC_OFS_MAP_38    = 16'h035c;
  localparam logic [15:0] DMSC_OFS_MAP_3A    = 16'h035d;
  localparam logic [15:0] DMSC_OFS_MAP_3C    = 16'h035e;
  localparam logic [15:0] DMSC_OFS_MAP_3E    = 16'h035f;
  localparam logic [15:0] DMSC_OFS_GLB_CTRL  = 16'h0370;
  localparam logic [15:0] DMSC_OFS_WRED_MAP  = 16'h0378;
  localparam int          DMSC_NUM_MAP       = 5;
  localparam logic [5:0]  DMSC_FIRST_CODE    = 6'h36;
  // Priority map: low field 2:0, high field 6:4
  localparam logic [7:0]  DMSC_MAP_MASK      = 8'h77;
  localparam logic [7:0]  DMSC_MAP_RST       = 8'h00;
  // Global control bits
  localparam int          DMSC_BIT_SNIFF_AND = 0;
  localparam int          DMSC_BIT_MLD_EN    = 2;
  localparam int          DMSC_BIT_MLD_OPT   = 3;
  localparam int          DMSC_BIT_IGMP_EN   = 6;
  localparam logic [7:0]  DMSC_CTRL_MASK     = 8'h4d;
  localparam logic [7:0]  DMSC_CTRL_RST      = 8'h00;
  // WRED color map: red 5:4, yellow 3:2, green 1:0
  localparam logic [7:0]  DMSC_WRED_MASK     = 8'h3f;
  localparam logic [7:0]  DMSC_WRED_RST      = 8'h39;
  // IPv6 next-header values
  localparam logic [7:0]  DMSC_NH_HOPOPT     = 8'h00;
  localparam logic [7:0]  DMSC_NH_ICMP       = 8'h01;
  localparam logic [7:0]  DMSC_NH_ICMPV6     = 8'h3a;
  localparam logic [7:0]  DMSC_NH_ROUTE      = 8'h2b;
  localparam logic [7:0]  DMSC_NH_FRAG       = 8'h2c;
  localparam logic [7:0]  DMSC_NH_ESP        = 8'h32;
  localparam logic [7:0]  DMSC_NH_AH         = 8'h33;
  localparam logic [7:0]  DMSC_NH_DSTOPT     = 8'h3c;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmsc_req_s;

  typedef struct packed {
    logic [1:0] red;
    logic [1:0] yellow;
    logic [1:0] green;
  } dmsc_color_s;
endpackage

// >>> bench/tb_dmsc_regs.sv
// Self-checking bench for the DSCP map, snoop and mirror control registers
module tb_dmsc_regs import dmsc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  logic             clk_in;
  logic             rst_n_in;
  dmsc_req_s        req_in;
  logic [7:0]       rdata_out;
  logic             rvalid_out;
  logic             hit_out;
  logic [5:0]       dscp_in;
  logic             dscp_hit_out;
  logic [2:0]       dscp_prio_out;
  logic             pkt_igmp_in;
  logic             pkt_ipv6_in;
  logic [7:0]       ipv6_nh_in;
  logic [7:0]       hbh_nh_in;
  logic             mld_match_out;
  logic             host_trap_out;
  logic             src_sniff_match_in;
  logic             dst_sniff_match_in;
  logic             port_mirror_en_in;
  logic             mirror_sel_out;
  dmsc_color_s      wred_color_out;
  logic             sniff_and_out;
  int               n_errors;
  int               tests_run;
  logic [31:0]      seed;
  logic [7:0]       shadow [7];
  localparam logic [15:0] ADDRS [7] = '{DMSC_OFS_MAP_36, DMSC_OFS_MAP_38, DMSC_OFS_MAP_3A, DMSC_OFS_MAP_3C,
                                        DMSC_OFS_MAP_3E, DMSC_OFS_GLB_CTRL, DMSC_OFS_WRED_MAP};
  localparam logic [7:0]  MASKS [7] = '{8'h77, 8'h77, 8'h77, 8'h77, 8'h77, 8'h4d, 8'h3f};
  localparam logic [7:0]  RSTV [7]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h39};
  // Next-header pool weighted towards the interesting codes, plus two that never match
  localparam logic [7:0]  NHS [10]  = '{8'h00, 8'h01, 8'h3a, 8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c, 8'h06, 8'h11};

  dmsc_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .hit_out(hit_out), .dscp_in(dscp_in), .dscp_hit_out(dscp_hit_out),
    .dscp_prio_out(dscp_prio_out), .pkt_igmp_in(pkt_igmp_in), .pkt_ipv6_in(pkt_ipv6_in),
    .ipv6_nh_in(ipv6_nh_in), .hbh_nh_in(hbh_nh_in), .mld_match_out(mld_match_out),
    .host_trap_out(host_trap_out), .src_sniff_match_in(src_sniff_match_in),
    .dst_sniff_match_in(dst_sniff_match_in), .port_mirror_en_in(port_mirror_en_in),
    .mirror_sel_out(mirror_sel_out), .wred_color_out(wred_color_out), .sniff_and_out(sniff_and_out));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [2:0] prio_f(input logic [5:0] c);
    logic [7:0] r;
    if (c < 6'h36) return 3'h0;
    r = shadow[(c - 6'h36) >> 1];
    return c[0] ? r[6:4] : r[2:0];
  endfunction

  function automatic logic mld_f(input logic opt, input logic v6, input logic [7:0] nh, input logic [7:0] hbh);
    logic [7:0] n;
    n = (nh == 8'h00) ? hbh : nh;
    if (opt) return v6 && (n inside {8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c});
    return v6 && (n inside {8'h01, 8'h3a});
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Called at a falling edge; leaves the request up so accesses can run back to back
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] rd,
                     output logic h);
    req_in = '{sel: 1'b1, wr: wr, addr: a, wdata: d};
    @(negedge clk_in);
    rd = rdata_out;
    h = hit_out;
    check({7'h00, rvalid_out}, {7'h00, ~wr});
  endtask

  task automatic reset_check();
    logic [7:0] rd;
    logic       h;
    for (int i = 0; i < 7; i++) begin
      shadow[i] = RSTV[i];
      bus(1'b0, ADDRS[i], 8'h00, rd, h);
      check(rd, RSTV[i]);
      check({7'h00, h}, 8'h01);
    end
    req_in = '0;
    check({2'b00, wred_color_out}, 8'h39);
    check({7'h00, sniff_and_out}, 8'h00);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] rd;
    logic       h;
    int         i;
    int         j;
    logic       opt;
    logic       trap;
    n_errors = 0;
    tests_run = 0;
    seed = 32'd9982;
    rst_n_in = 1'b0;
    req_in = '0;
    {dscp_in, pkt_igmp_in, pkt_ipv6_in, ipv6_nh_in, hbh_nh_in} = '0;
    {src_sniff_match_in, dst_sniff_match_in, port_mirror_en_in} = '0;
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    reset_check();
    // Neighbours of the control register and the map are unmapped: a write to 0x0371 reads back zero and both reads see hit low
    bus(1'b1, 16'h0371, 8'hff, rd, h);
    bus(1'b0, 16'h0371, 8'h00, rd, h);
    check(rd, 8'h00);
    check({7'h00, h}, 8'h00);
    bus(1'b0, 16'h035a, 8'h00, rd, h);
    check(rd, 8'h00);
    check({7'h00, h}, 8'h00);
    for (int k = 0; k < 300; k++) begin
      i = rnd() % 7;
      j = rnd() % 2 ? i : rnd() % 7;
      bus(1'b1, ADDRS[i], 8'(rnd()), rd, h);
      shadow[i] = req_in.wdata & MASKS[i];
      bus(1'b0, ADDRS[j], 8'h00, rd, h);
      req_in = '0;
      check(rd, shadow[j]);
      dscp_in = (k < 10) ? 6'(6'h36 + k[5:0]) : 6'(rnd());
      {pkt_igmp_in, pkt_ipv6_in, src_sniff_match_in, dst_sniff_match_in, port_mirror_en_in} = 5'(rnd());
      ipv6_nh_in = NHS[rnd() % 10];
      hbh_nh_in = NHS[rnd() % 10];
      opt = shadow[5][3];
      trap = (shadow[5][6] & pkt_igmp_in) | (shadow[5][2] & mld_f(opt, pkt_ipv6_in, ipv6_nh_in, hbh_nh_in));
      // Look well before the next rising edge, while the combinational outputs have settled
      #20;
      check({4'h0, dscp_hit_out, dscp_prio_out}, {4'h0, dscp_in >= 6'h36, prio_f(dscp_in)});
      check({7'h00, mld_match_out}, {7'h00, mld_f(opt, pkt_ipv6_in, ipv6_nh_in, hbh_nh_in)});
      check({7'h00, host_trap_out}, {7'h00, trap});
      check({7'h00, mirror_sel_out}, {7'h00, port_mirror_en_in & (shadow[5][0] ? src_sniff_match_in &
            dst_sniff_match_in : src_sniff_match_in | dst_sniff_match_in)});
      check({1'b0, sniff_and_out, wred_color_out}, {1'b0, shadow[5][0], shadow[6][5:0]});
      @(negedge clk_in);
    end
    // A second reset mid-run must bring every field back
    rst_n_in = 1'b0;
    @(negedge clk_in);
    rst_n_in = 1'b1;
    reset_check();
    print_verdict();
  end
endmodule
